/* src/fetx_pkg.sv */
// Package of constants, types and code tables for the fast Ethernet transmit coding path.
package fetx_pkg;

  // Code-group, nibble, address and scrambler widths, and the FIFO depth.
  localparam int unsigned CODE_W  = 5;
  localparam int unsigned NIB_W   = 4;
  localparam int unsigned ADDR_W  = 5;
  localparam int unsigned LFSR_W  = 11;
  localparam int unsigned FIFO_DEPTH = 32;

  // Control code-groups.
  localparam logic [4:0] CODE_J    = 5'h18;  // 11000, first half of the start pair.
  localparam logic [4:0] CODE_K    = 5'h11;  // 10001, second half of the start pair.
  localparam logic [4:0] CODE_T    = 5'h0D;  // 01101, first half of the end pair.
  localparam logic [4:0] CODE_R    = 5'h07;  // 00111, second half of the end pair.
  localparam logic [4:0] CODE_IDLE = 5'h1F;  // 11111, idle fill.
  localparam logic [4:0] CODE_H    = 5'h04;  // 00100, transmit error.

  // Scrambler feedback taps (x^11 + x^9 + 1) and seed fill bits.
  localparam int unsigned LFSR_TAP_HI = 10;
  localparam int unsigned LFSR_TAP_LO = 8;
  localparam logic        SEED_FILL   = 1'b1;
  localparam logic [1:0]  SEED_WAIT   = 2'h3;  // Cycles the seed is reloaded after reset.

  // Timing: system clock period, dibit period on the MAC side and serial bit period, in ns.
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned DIBIT_NS      = 20;  // 50 MHz reference rate.
  localparam int unsigned BIT_NS        = 8;   // 125 MHz serial rate.
  // Least times round up, and nothing is shorter than one cycle.
  localparam int unsigned DIBIT_CYC_RAW = (DIBIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DIBIT_CYC     = (DIBIT_CYC_RAW < 1) ? 1 : DIBIT_CYC_RAW;
  localparam int unsigned BIT_CYC_RAW   = (BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BIT_CYC       = (BIT_CYC_RAW < 1) ? 1 : BIT_CYC_RAW;
  localparam logic [2:0]  LAST_BIT      = 3'h4;  // Index of the last bit of a code-group.

  // MLT-3 level walk: zero, plus, zero, minus.
  localparam logic [1:0] MLT_ZERO_A = 2'h0;
  localparam logic [1:0] MLT_PLUS   = 2'h1;
  localparam logic [1:0] MLT_ZERO_B = 2'h2;
  localparam logic [1:0] MLT_MINUS  = 2'h3;

  // Front-end states, Gray coded along idle, start, data, end.
  typedef enum logic [1:0] {
    FETX_IDLE = 2'h0,
    FETX_SSDK = 2'h1,
    FETX_DATA = 2'h3,
    FETX_ESDR = 2'h2
  } fetx_state_t;

  // Maps a data nibble to its code-group.
  function automatic logic [4:0] fetx_encode(input logic [3:0] nib);
    logic [4:0] c;
    c = CODE_IDLE;
    unique case (nib)
      4'h0: c = 5'h1E;
      4'h1: c = 5'h09;
      4'h2: c = 5'h14;
      4'h3: c = 5'h15;
      4'h4: c = 5'h0A;
      4'h5: c = 5'h0B;
      4'h6: c = 5'h0E;
      4'h7: c = 5'h0F;
      4'h8: c = 5'h12;
      4'h9: c = 5'h13;
      4'hA: c = 5'h16;
      4'hB: c = 5'h17;
      4'hC: c = 5'h1A;
      4'hD: c = 5'h1B;
      4'hE: c = 5'h1C;
      4'hF: c = 5'h1D;
    endcase
    return c;
  endfunction

  // Maps a code-group back to {is_data, nibble}.
  function automatic logic [4:0] fetx_decode(input logic [4:0] c);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (fetx_encode(4'(i)) == c) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // True for the code-groups that are never sent and flag an error on receive.
  function automatic logic fetx_invalid(input logic [4:0] c);
    return (c == 5'h00) || (c == 5'h01) || (c == 5'h02) || (c == 5'h03) || (c == 5'h05) ||
           (c == 5'h06) || (c == 5'h08) || (c == 5'h0C) || (c == 5'h10) || (c == 5'h19);
  endfunction

endpackage

/* src/fetx_fifo_if.sv */
// Interface carrying code-groups between the encoder front end and the FIFO.
`timescale 1ns/1ps
interface fetx_fifo_if #(
  parameter int unsigned W = 5
);
  logic         wr_valid;  // Writer offers a word.
  logic         wr_ready;  // FIFO has room.
  logic [W-1:0] wr_data;   // Word being offered.
  logic         rd_valid;  // FIFO output register holds a word.
  logic         rd_ready;  // Reader takes the word this cycle.
  logic [W-1:0] rd_data;   // Registered output word.

  modport src  (output wr_valid, output wr_data, input wr_ready,
                input rd_valid, input rd_data, output rd_ready);
  modport fifo (input wr_valid, input wr_data, output wr_ready,
                output rd_valid, output rd_data, input rd_ready);
endinterface

/* src/fetx_fifo.sv */
// Code-group FIFO with a registered output word and honest full and empty.
`timescale 1ns/1ps
module fetx_fifo #(
  parameter int unsigned W     = 5,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  fetx_fifo_if.fifo port_f
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];   // Storage array.
  logic [AW:0]  wp_q, wp_d;    // Write pointer with wrap bit.
  logic [AW:0]  rp_q, rp_d;    // Read pointer with wrap bit.
  logic [W-1:0] out_q, out_d;  // Output register.
  logic         ov_q, ov_d;    // Output register holds a word.
  logic         empty, full;   // Storage state.
  logic         push, pull;    // Storage moves this cycle.

  assign empty = (wp_q == rp_q);
  assign full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign port_f.wr_ready = !full;
  assign port_f.rd_valid = ov_q;
  assign port_f.rd_data  = out_q;

  // Next-state logic: refill the output register whenever it is free or being taken.
  always_comb begin
    push  = port_f.wr_valid && !full;
    pull  = !empty && (!ov_q || port_f.rd_ready);
    wp_d  = push ? wp_q + 1'b1 : wp_q;
    rp_d  = pull ? rp_q + 1'b1 : rp_q;
    out_d = pull ? mem[rp_q[AW-1:0]] : out_q;
    ov_d  = pull ? 1'b1 : (port_f.rd_ready ? 1'b0 : ov_q);
  end

  // Registers; the array itself has no reset, which keeps it a plain memory.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= port_f.wr_data;
    end
    if (!reset_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      out_q <= '0;
      ov_q  <= 1'b0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      out_q <= out_d;
      ov_q  <= ov_d;
    end
  end
endmodule

/* src/fetx_tx_coder.sv */
// Transmit coding path: dibit assembly, 4B/5B encoding, scrambling, serialising, NRZI and MLT-3.
`timescale 1ns/1ps
module fetx_tx_coder #(
  parameter int unsigned DIBIT_CYC  = fetx_pkg::DIBIT_CYC,
  parameter int unsigned FIFO_DEPTH = fetx_pkg::FIFO_DEPTH
) (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       tx_en_pin,
  input  wire logic [1:0] tx_dibit_pin,
  input  wire logic       tx_err_pin,
  input  wire logic [4:0] phy_mgmt_address,
  output logic            tx_ready,
  input  wire logic [4:0] rx_code,
  input  wire logic       rx_code_vld,
  input  wire logic       rx_dv,
  output logic [3:0]      rx_nibble,
  output logic            rx_err,
  output logic            tx_nrzi,
  output logic            line_out_pos,
  output logic            line_out_neg
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [1:0] en_s_q;     // Enable synchroniser stages.
  logic [3:0] dib_s_q;    // Dibit synchroniser, two stages of two bits.
  logic [1:0] err_s_q;    // Error synchroniser stages.
  logic [9:0] addr_s_q;   // Address synchroniser, two stages of five bits.
  logic       en_s;       // Synchronised enable.
  logic [1:0] dib_s;      // Synchronised dibit.
  logic       err_s;      // Synchronised error.
  logic [4:0] addr_s;     // Synchronised address.

  // Every tx pin and the address cross two flops; only the second stage is read.
  always_ff @(posedge clk_sys) begin
    en_s_q   <= {en_s_q[0], tx_en_pin};
    dib_s_q  <= {dib_s_q[1:0], tx_dibit_pin};
    err_s_q  <= {err_s_q[0], tx_err_pin};
    addr_s_q <= {addr_s_q[4:0], phy_mgmt_address};
  end

  assign en_s   = en_s_q[1];
  assign dib_s  = dib_s_q[3:2];
  assign err_s  = err_s_q[1];
  assign addr_s = addr_s_q[9:5];

  ////////////////////////////////////////////////////////////////////////////////
  // Dibit sample divider.

  localparam int unsigned DW = (DIBIT_CYC > 1) ? $clog2(DIBIT_CYC) : 1;
  logic [DW-1:0] div_q, div_d;  // Sample divider count.
  logic          tick;          // One-cycle sample enable at the dibit rate.

  // Divider: one sample pulse every DIBIT_CYC cycles.
  always_comb begin
    tick  = (div_q == DW'(DIBIT_CYC - 1));
    div_d = tick ? '0 : div_q + 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Front end: assemble nibbles and pick the code-group for the FIFO.

  fetx_fifo_if #(.W(fetx_pkg::CODE_W)) fq ();

  fetx_pkg::fetx_state_t st_q, st_d;  // Front-end state.
  logic       half_q, half_d;         // Low dibit of the nibble is held.
  logic [1:0] low_q, low_d;           // Held low dibit.
  logic       nerr_q, nerr_d;         // Error seen during this nibble.
  logic [4:0] code_q, code_d;         // Pending code-group.
  logic       pend_q, pend_d;         // Pending code-group not yet taken by the FIFO.
  logic [4:0] hold_q, hold_d;         // First nibble parked behind K; the idle code means empty.
  logic       slot;                   // Pending slot is free or being freed.
  logic       step;                   // Front end consumes a sample this cycle.

  // The pending slot stalls sampling, so a full FIFO pushes back to the MAC via tx_ready.
  assign slot     = !pend_q || fq.wr_ready;
  assign step     = tick && slot;
  assign tx_ready = slot;
  assign fq.wr_valid = pend_q;
  assign fq.wr_data  = code_q;

  // Next-state logic of the front end.
  always_comb begin
    st_d   = st_q;
    half_d = half_q;
    low_d  = low_q;
    nerr_d = nerr_q;
    code_d = code_q;
    hold_d = hold_q;
    pend_d = pend_q && !fq.wr_ready;
    unique case (st_q)
      fetx_pkg::FETX_IDLE: begin
        // Dibits with enable low are ignored whatever their value.
        if (step && en_s) begin
          code_d = fetx_pkg::CODE_J;
          pend_d = 1'b1;
          low_d  = dib_s;
          half_d = 1'b1;
          nerr_d = err_s;
          st_d   = fetx_pkg::FETX_SSDK;
        end
      end
      fetx_pkg::FETX_SSDK: begin
        // K follows J as soon as the slot frees, before any data group.
        if (slot) begin
          code_d = fetx_pkg::CODE_K;
          pend_d = 1'b1;
          st_d   = fetx_pkg::FETX_DATA;
        end
        if (step && en_s) begin
          // The first nibble completes while K holds the slot, so it is parked for one slot.
          hold_d = (nerr_q || err_s) ? fetx_pkg::CODE_H : fetx_pkg::fetx_encode({dib_s, low_q});
          half_d = 1'b0;
        end
      end
      fetx_pkg::FETX_DATA: begin
        if (hold_q != fetx_pkg::CODE_IDLE && slot) begin
          code_d = hold_q;
          pend_d = 1'b1;
          hold_d = fetx_pkg::CODE_IDLE;
          low_d  = dib_s;
          half_d = step && en_s;
          nerr_d = err_s;
        end else if (step && !en_s) begin
          // A trailing half nibble is dropped; the end pair closes the stream.
          code_d = fetx_pkg::CODE_T;
          pend_d = 1'b1;
          half_d = 1'b0;
          st_d   = fetx_pkg::FETX_ESDR;
        end else if (step && half_q) begin
          // An error in either half replaces the whole nibble.
          code_d = (nerr_q || err_s) ? fetx_pkg::CODE_H
                                     : fetx_pkg::fetx_encode({dib_s, low_q});
          pend_d = 1'b1;
          half_d = 1'b0;
          nerr_d = 1'b0;
        end else if (step) begin
          low_d  = dib_s;
          half_d = 1'b1;
          nerr_d = err_s;
        end
      end
      fetx_pkg::FETX_ESDR: begin
        if (slot) begin
          code_d = fetx_pkg::CODE_R;
          pend_d = 1'b1;
          st_d   = fetx_pkg::FETX_IDLE;
        end
      end
    endcase
  end

  // Front-end registers.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_q   <= fetx_pkg::FETX_IDLE;
      half_q <= 1'b0;
      low_q  <= 2'h0;
      nerr_q <= 1'b0;
      code_q <= fetx_pkg::CODE_IDLE;
      hold_q <= fetx_pkg::CODE_IDLE;
      pend_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      half_q <= half_d;
      low_q  <= low_d;
      nerr_q <= nerr_d;
      code_q <= code_d;
      hold_q <= hold_d;
      pend_q <= pend_d;
    end
  end

  // Buffer between the dibit rate and the serial rate.
  fetx_fifo #(
    .W     (fetx_pkg::CODE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .port_f  (fq.fifo)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Serial side: shift out, scramble, NRZI and MLT-3, one bit per cycle.

  logic [4:0]  sh_q, sh_d;      // Code-group shift register, MSB first.
  logic [2:0]  bit_q, bit_d;    // Bit index within the code-group.
  logic [10:0] lfsr_q, lfsr_d;  // Scrambler state.
  logic [1:0]  seed_q, seed_d;  // Seed reload countdown after reset.
  logic        nrzi_q, nrzi_d;  // NRZI line bit.
  logic [1:0]  mlt_q, mlt_d;    // MLT-3 level index.
  logic        sbit;            // Scrambled bit of this cycle.
  logic        last;            // Last bit of the code-group goes out now.

  assign last = (bit_q == fetx_pkg::LAST_BIT);
  assign fq.rd_ready = last;
  assign sbit = sh_q[4] ^ lfsr_q[fetx_pkg::LFSR_TAP_HI];

  // Next-state logic of the serial chain; all of it steps on the one clock.
  always_comb begin
    bit_d  = last ? 3'h0 : bit_q + 3'h1;
    // An empty FIFO at a group boundary yields idle, so idle fills every gap.
    sh_d   = last ? (fq.rd_valid ? fq.rd_data : fetx_pkg::CODE_IDLE)
                  : {sh_q[3:0], 1'b0};
    seed_d = (seed_q != 2'h0) ? seed_q - 2'h1 : 2'h0;
    // The address picks the seed; the fill bit keeps the state away from all zeros.
    lfsr_d = (seed_q != 2'h0)
           ? {fetx_pkg::SEED_FILL, addr_s, ~addr_s}
           : {lfsr_q[9:0], lfsr_q[fetx_pkg::LFSR_TAP_HI] ^ lfsr_q[fetx_pkg::LFSR_TAP_LO]};
    nrzi_d = nrzi_q ^ sbit;
    mlt_d  = sbit ? mlt_q + 2'h1 : mlt_q;
  end

  // Serial registers.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      bit_q  <= 3'h0;
      sh_q   <= fetx_pkg::CODE_IDLE;
      seed_q <= fetx_pkg::SEED_WAIT;
      lfsr_q <= '1;
      nrzi_q <= 1'b0;
      mlt_q  <= fetx_pkg::MLT_ZERO_A;
    end else begin
      bit_q  <= bit_d;
      sh_q   <= sh_d;
      seed_q <= seed_d;
      lfsr_q <= lfsr_d;
      nrzi_q <= nrzi_d;
      mlt_q  <= mlt_d;
    end
  end

  // Line outputs; both low means the zero level.
  assign tx_nrzi      = nrzi_q;
  assign line_out_pos = (mlt_q == fetx_pkg::MLT_PLUS);
  assign line_out_neg = (mlt_q == fetx_pkg::MLT_MINUS);

  ////////////////////////////////////////////////////////////////////////////////
  // Receive-side meaning of a code-group.

  logic [3:0] rxn_q, rxn_d;  // Decoded nibble.
  logic       rxe_q, rxe_d;  // Receive error flag.
  logic [4:0] rx_dec;        // {is_data, nibble}.

  // Decode; invalid groups only count as errors while data valid is active.
  always_comb begin
    rx_dec = fetx_pkg::fetx_decode(rx_code);
    rxn_d  = (rx_code_vld && rx_dec[4]) ? rx_dec[3:0] : rxn_q;
    rxe_d  = rx_code_vld && rx_dv && fetx_pkg::fetx_invalid(rx_code);
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rxn_q <= 4'h0;
      rxe_q <= 1'b0;
    end else begin
      rxn_q <= rxn_d;
      rxe_q <= rxe_d;
    end
  end

  assign rx_nibble = rxn_q;
  assign rx_err    = rxe_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_ssd_start: assert property (st_q == fetx_pkg::FETX_IDLE && step && en_s
    |=> code_q == fetx_pkg::CODE_J && pend_q ##[1:40] code_q == fetx_pkg::CODE_K)
    else $error("Start pair not sent after enable rise.");

  a_esd_end: assert property (st_q == fetx_pkg::FETX_DATA && step && !en_s && hold_q == fetx_pkg::CODE_IDLE
    |=> code_q == fetx_pkg::CODE_T ##[1:40] code_q == fetx_pkg::CODE_R)
    else $error("End pair not sent after enable fall.");

  a_data_code: assert property (st_q == fetx_pkg::FETX_DATA && step && en_s && half_q && !nerr_q && !err_s
    |=> code_q == fetx_pkg::fetx_encode({$past(dib_s), $past(low_q)}))
    else $error("Data nibble encoded to the wrong code-group.");

  a_err_code: assert property (st_q == fetx_pkg::FETX_DATA && step && en_s && half_q && err_s
    |=> code_q == fetx_pkg::CODE_H)
    else $error("Transmit error did not send the error code-group.");

  a_no_invalid: assert property (last |-> !fetx_pkg::fetx_invalid(sh_d))
    else $error("An invalid code-group was loaded for sending.");

  a_idle_fill: assert property (last && !fq.rd_valid |=> sh_q == fetx_pkg::CODE_IDLE && bit_q == 3'h0)
    else $error("Idle not sent while the buffer is empty.");

  a_piso_count: assert property (bit_q == 3'h0 |-> ##4 bit_q == fetx_pkg::LAST_BIT ##1 bit_q == 3'h0)
    else $error("Code-group not shifted out in five cycles.");

  a_mlt_step: assert property (sbit |=> mlt_q == $past(mlt_q) + 2'h1 && nrzi_q != $past(nrzi_q))
    else $error("A one bit did not step the line level.");

  a_mlt_hold: assert property (!sbit |=> $stable(mlt_q) && $stable(nrzi_q))
    else $error("A zero bit moved the line level.");

  a_seed_load: assert property (seed_q == 2'h1 |=> lfsr_q == {fetx_pkg::SEED_FILL, $past(addr_s), ~$past(addr_s)})
    else $error("Scrambler seed not taken from the address.");

  a_idle_ignore: assert property (st_q == fetx_pkg::FETX_IDLE && !en_s |=> $stable(low_q) && !pend_q)
    else $error("Dibits taken while enable is low.");

  a_rx_invalid: assert property (rx_code_vld && rx_dv && fetx_pkg::fetx_invalid(rx_code) |=> rx_err)
    else $error("Invalid received code-group not flagged.");

endmodule

/* tb/fetx_mac_model.sv */
// MAC-side partner model that drives enable, dibits and error on the reduced interface.
`timescale 1ns/1ps
module fetx_mac_model (
  input  wire logic  clk_sys,
  output logic       tx_en_pin,
  output logic [1:0] tx_dibit_pin,
  output logic       tx_err_pin
);
  // Pins start low, as a quiet MAC leaves them between frames.
  initial begin
    tx_en_pin    = 1'b0;
    tx_dibit_pin = 2'h0;
    tx_err_pin   = 1'b0;
  end

  // Sends n nibbles, one dibit per falling edge; err_at marks one whole nibble as errored.
  task automatic send(input logic [3:0] nib [16], input int n, input int err_at);
    for (int i = 0; i < 2 * n; i++) begin
      @(negedge clk_sys);
      tx_en_pin    = 1'b1;
      tx_dibit_pin = i[0] ? nib[i / 2][3:2] : nib[i / 2][1:0];
      tx_err_pin   = (i / 2 == err_at);
    end
    @(negedge clk_sys);
    tx_en_pin    = 1'b0;
    tx_dibit_pin = 2'h0;
    tx_err_pin   = 1'b0;
  endtask

  // Breaks the quiet-dibit habit on purpose: a non-zero value while enable is low.
  task automatic junk(input int cycles);
    @(negedge clk_sys);
    tx_dibit_pin = 2'h3;
    repeat (cycles) @(negedge clk_sys);
    tx_dibit_pin = 2'h0;
  endtask
endmodule

/* tb/fetx_tx_coder_bench.sv */
// Self-checking bench for the transmit coding path, with a line monitor that descrambles.
`timescale 1ns/1ps
module fetx_tx_coder_bench;
  logic       clk_sys;           // 20 MHz system clock.
  logic       reset_n;           // Synchronous active-low reset.
  logic       tx_en_pin;         // Driven by the MAC model.
  logic [1:0] tx_dibit_pin;      // Driven by the MAC model.
  logic       tx_err_pin;        // Driven by the MAC model.
  logic [4:0] phy_mgmt_address;  // Address strap that seeds the scrambler.
  logic       tx_ready;          // Sample slot free.
  logic [4:0] rx_code;           // Code-group for the decoder.
  logic       rx_code_vld;       // Decoder strobe.
  logic       rx_dv;             // Receive data valid level.
  logic [3:0] rx_nibble;         // Decoded nibble.
  logic       rx_err;            // Invalid code-group pulse.
  logic       tx_nrzi;           // Serial NRZI bit.
  logic       line_out_pos;      // MLT-3 plus level.
  logic       line_out_neg;      // MLT-3 minus level.
  int         failures;          // Mismatches seen.
  int         checks_done;       // Comparisons made.
  logic [4:0] enc [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                           5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic [31:0] bad_mask = 32'h0201_116F;  // One bit per code-group that is never legal.
  logic        prev_n, s, k, p, in_frame; // Monitor state and per-bit values.
  logic [1:0]  lvl;                       // Expected MLT-3 level index.
  logic [10:0] h, snap;                   // Keystream history and a snapshot of it.
  logic [9:0]  w;                         // Last ten plain bits, for start-pair search.
  logic [4:0]  acc;                       // Code-group being gathered.
  int          cnt, bcnt;                 // Bits since reset and bits in the group.
  logic [4:0]  grp [$];                   // Code-groups recovered inside a frame.

  fetx_tx_coder uut (.clk_sys(clk_sys), .reset_n(reset_n), .tx_en_pin(tx_en_pin),
    .tx_dibit_pin(tx_dibit_pin), .tx_err_pin(tx_err_pin), .phy_mgmt_address(phy_mgmt_address),
    .tx_ready(tx_ready), .rx_code(rx_code), .rx_code_vld(rx_code_vld), .rx_dv(rx_dv),
    .rx_nibble(rx_nibble), .rx_err(rx_err), .tx_nrzi(tx_nrzi), .line_out_pos(line_out_pos),
    .line_out_neg(line_out_neg));

  fetx_mac_model mac (.clk_sys(clk_sys), .tx_en_pin(tx_en_pin), .tx_dibit_pin(tx_dibit_pin),
    .tx_err_pin(tx_err_pin));

  // Free-running clock, 50 ns period.
  always #25 clk_sys = ~clk_sys;

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Line monitor: MLT-3 walk, keystream learning on idle, then descrambling and framing.
  // The key is learned from idle fill, so it works whatever the seed was; the cost is
  // that frames sent in the first forty cycles after reset would be missed.
  always @(negedge clk_sys) begin
    if (!reset_n) begin
      prev_n   = 1'b0;
      lvl      = 2'h0;
      cnt      = 0;
      w        = '1;
      in_frame = 1'b0;
    end else begin
      s      = tx_nrzi ^ prev_n;
      prev_n = tx_nrzi;
      lvl    = lvl + {1'b0, s};
      chk("line_out_pos", 32'(lvl == 2'h1), 32'(line_out_pos));
      chk("line_out_neg", 32'(lvl == 2'h3), 32'(line_out_neg));
      cnt++;
      k = (cnt < 40) ? ~s : (h[10] ^ h[8]);
      p = s ^ k;
      h = {h[9:0], k};
      if (cnt == 60) begin
        snap = h;
      end
      if (cnt >= 40) begin
        if (!in_frame) begin
          chk("idle_bit", 32'h1, 32'(w[9]));
          w = {w[8:0], p};
          if (w == 10'b1100010001) begin
            in_frame = 1'b1;
            bcnt     = 0;
          end
        end else begin
          acc = {acc[3:0], p};
          bcnt++;
          if (bcnt == 5) begin
            grp.push_back(acc);
            bcnt = 0;
            if (acc == 5'h1F) begin
              in_frame = 1'b0;
              w        = '1;
            end
          end
        end
      end
    end
  end

  // Holds reset for six cycles with the given address strap.
  task automatic do_reset(input logic [4:0] addr);
    @(negedge clk_sys);
    reset_n          = 1'b0;
    phy_mgmt_address = addr;
    repeat (6) @(negedge clk_sys);
    reset_n = 1'b1;
  endtask

  // Two addresses must give two different keystreams at the same point after reset.
  task automatic t_seed();
    logic [10:0] first;
    do_reset(5'h05);
    repeat (70) @(negedge clk_sys);
    first = snap;
    do_reset(5'h1A);
    repeat (70) @(negedge clk_sys);
    checks_done++;
    if (snap === first) begin
      failures++;
      $display("[ERR] keystream expected change seen %0h", snap);
    end
  endtask

  // Sends one frame and compares the recovered groups with the expected stream.
  task automatic t_frame(input logic [3:0] nib [16], input int n, input int err_at);
    logic [4:0] exp [$];
    for (int i = 0; i < n; i++) begin
      exp.push_back((i == err_at) ? 5'h04 : enc[nib[i]]);
    end
    exp.push_back(5'h0D);
    exp.push_back(5'h07);
    exp.push_back(5'h1F);
    grp.delete();
    mac.send(nib, n, err_at);
    for (int t = 0; t < 600 && grp.size() < n + 3; t++) begin
      @(negedge clk_sys);
    end
    if (grp.size() < n + 3) begin
      failures++;
      $display("[ERR] frame_groups expected %0d seen %0d", n + 3, grp.size());
      report_and_stop();
    end
    chk("tx_ready", 32'h1, 32'(tx_ready));
    for (int i = 0; i < n + 3; i++) begin
      chk("frame_group", 32'(exp[i]), 32'(grp[i]));
    end
  endtask

  // Walks every code-group through the decoder back to back, then one with valid low.
  task automatic t_rx();
    logic [3:0] exp_nib;
    logic       exp_err;
    exp_nib = 4'h0;
    exp_err = 1'b0;
    for (int i = 0; i <= 32; i++) begin
      @(negedge clk_sys);
      if (i > 0) begin
        chk("rx_err", 32'(exp_err), 32'(rx_err));
        chk("rx_nibble", 32'(exp_nib), 32'(rx_nibble));
      end
      rx_code_vld = 1'b1;
      rx_dv       = (i < 32);
      rx_code     = 5'(i);
      exp_err     = (i < 32) && bad_mask[i];
      for (int j = 0; j < 16 && i < 32; j++) begin
        if (enc[j] == 5'(i)) begin
          exp_nib = 4'(j);
        end
      end
    end
    @(negedge clk_sys);
    chk("rx_err_no_dv", 32'h0, 32'(rx_err));
    rx_code_vld = 1'b0;
  endtask

  // Main sequence.
  initial begin
    logic [3:0] nib [16];
    clk_sys          = 1'b0;
    reset_n          = 1'b0;
    phy_mgmt_address = 5'h05;
    rx_code          = 5'h00;
    rx_code_vld      = 1'b0;
    rx_dv            = 1'b0;
    failures         = 0;
    checks_done      = 0;
    t_seed();
    for (int i = 0; i < 16; i++) begin
      nib[i] = 4'(i);
    end
    t_frame(nib, 16, -1);
    mac.junk(5);
    nib[0] = 4'h3;
    nib[1] = 4'hC;
    nib[2] = 4'h5;
    t_frame(nib, 3, 1);
    t_rx();
    report_and_stop();
  end
endmodule
